// *** pkg/ccd_pkg.sv ***
// Constants and types for calibration scaling and command decoding
package ccd_pkg;
  // ==========================================================
  // Command opcodes (control group ignores bit 0)
  localparam logic [6:0] OPC_WAKE     = 7'h00;
  localparam logic [6:0] OPC_STANDBY  = 7'h01;
  localparam logic [6:0] OPC_ALIGN    = 7'h02;
  localparam logic [6:0] OPC_RESET    = 7'h03;
  localparam logic [7:0] CMD_CONT     = 8'h10;
  localparam logic [7:0] CMD_STOP     = 8'h11;
  localparam logic [7:0] CMD_RDC      = 8'h12;
  localparam logic [7:0] CMD_OFS_CAL  = 8'h60;
  localparam logic [7:0] CMD_GAIN_CAL = 8'h61;
  localparam logic [2:0] GRP_REG_RD   = 3'h1;
  localparam logic [2:0] GRP_REG_WR   = 3'h2;
  // ==========================================================
  // Register addresses of the correction words
  localparam logic [4:0] ADDR_OFS0  = 5'h05;
  localparam logic [4:0] ADDR_OFS1  = 5'h06;
  localparam logic [4:0] ADDR_OFS2  = 5'h07;
  localparam logic [4:0] ADDR_GAIN0 = 5'h08;
  localparam logic [4:0] ADDR_GAIN1 = 5'h09;
  localparam logic [4:0] ADDR_GAIN2 = 5'h0A;
  // ==========================================================
  // Reset values and arithmetic constants
  localparam logic [23:0] OFS_RESET    = 24'h00_0000;
  localparam logic [23:0] GAIN_RESET   = 24'h40_0000;
  localparam logic [23:0] GAIN_DOUBLE  = 24'h80_0000;
  localparam logic [23:0] GAIN_MAX     = 24'hFF_FFFF;
  localparam int          GAIN_FRAC    = 22;
  localparam logic [31:0] CAL_FULL     = 32'h7FFF_FFFE;
  localparam logic [31:0] SAT_POS      = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG      = 32'h8000_0000;
  // ==========================================================
  // Cycle and reading counts
  localparam logic [6:0] SETTLE_READS = 7'h40;
  localparam logic [4:0] CAL_READS    = 5'h10;
  localparam int         CAL_SHIFT    = 4;
  localparam logic [2:0] READY_HIGH   = 3'h4;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [4:0] WORD_LEFT    = 5'h1F;
  localparam logic [4:0] BYTE_LEFT    = 5'h07;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CNT  = 4'b0010,
    ST_WR   = 4'b0100,
    ST_RD   = 4'b1000
  } ccd_state_t;
  typedef enum logic [2:0] {
    CAL_NONE = 3'b001,
    CAL_OFS  = 3'b010,
    CAL_GAIN = 3'b100
  } ccd_cal_t;
endpackage

// *** rtl/ccd_link.sv ***
// Serial link end: command bytes in, result bits out, on the link clock
`timescale 1ns/100ps
module ccd_link
  import ccd_pkg::*;
(
  // Link clock and reset
  input  wire logic        sclk_in,
  input  wire logic        nrst_in,
  // Serial pins
  input  wire logic        din_in,
  output logic             dout_out,
  // Core side: quasi-static word and mode, toggle per byte
  input  wire logic [31:0] tx_word_in,
  input  wire logic        word_mode_in,
  output logic [7:0]       rx_byte_out,
  output logic             rx_tgl_out
);
  typedef struct packed {
    logic [2:0]  bcnt;
    logic [6:0]  rx_sh;
    logic [7:0]  rx_byte;
    logic        rx_tgl;
    logic [4:0]  ocnt;
    logic [30:0] sh;
    logic        dout;
  } ccd_link_t;

  ccd_link_t link_r;
  ccd_link_t link_nxt;

  // ==========================================================
  // Shifting. tx_word_in and word_mode_in change only while the
  // link is idle between bytes, so they are read without a
  // synchroniser; the byte toggle is the handshake back.
  always_comb begin
    link_nxt       = link_r;
    link_nxt.rx_sh = {link_r.rx_sh[5:0], din_in};
    link_nxt.bcnt  = link_r.bcnt + 3'h1;
    if (link_r.bcnt == BIT_LAST) begin
      link_nxt.rx_byte = {link_r.rx_sh, din_in};
      link_nxt.rx_tgl  = ~link_r.rx_tgl;
    end
    // Leaving word mode abandons a half-sent word
    if (link_r.bcnt == 3'h0 &&
        (!word_mode_in || link_r.ocnt == 5'h00)) begin
      link_nxt.dout = tx_word_in[31];
      link_nxt.sh   = tx_word_in[30:0];
      link_nxt.ocnt = word_mode_in ? WORD_LEFT : BYTE_LEFT;
    end else begin
      link_nxt.dout = link_r.sh[30];              // Next word bit; the word reloads after its 32nd bit
      link_nxt.sh   = {link_r.sh[29:0], 1'b0};
      if (link_r.ocnt != 5'h00) begin
        link_nxt.ocnt = link_r.ocnt - 5'h01;
      end
    end
  end

  always_ff @(posedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  assign dout_out    = link_r.dout;
  assign rx_byte_out = link_r.rx_byte;
  assign rx_tgl_out  = link_r.rx_tgl;
endmodule // ccd_link

// *** rtl/ccd_cal_decode.sv ***
// Offset/gain correction, self-calibration and serial command decoder
`timescale 1ns/100ps
module ccd_cal_decode
  import ccd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Serial link
  input  wire logic        sclk_in,
  input  wire logic        din_in,
  output logic             dout_out,
  output logic             result_ready_n_out,
  input  wire logic        sync_in,
  // Filter side
  input  wire logic [31:0] filt_data_in,
  input  wire logic        filt_valid_in,
  input  wire logic        sinc_only_in,
  // Results and status
  output logic [31:0]      result_out,
  output logic             result_valid_out,
  output logic             standby_out,
  output logic             restart_out,
  output logic             cal_busy_out
);
  typedef struct packed {
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_s3;
    logic        sy_s1;
    logic        sy_s2;
    ccd_state_t  st;
    logic        wr;
    logic [4:0]  addr;
    logic [4:0]  left;
    logic [23:0] ofs;
    logic [23:0] gain;
    logic        cont;
    logic        rdc_wait;
    logic        rdc_mode;
    logic        standby;
    logic        word_mode;
    logic [31:0] tx_word;
    logic [31:0] result;
    logic        res_valid;
    logic        ready_n;
    logic        restart;
    logic [2:0]  hi_cnt;
    logic [6:0]  settle;
    ccd_cal_t    cal_arm;
    ccd_cal_t    cal_op;
    logic        cal_run;
    logic [4:0]  cal_cnt;
    logic [35:0] acc;
  } ccd_core_t;

  ccd_core_t   core_r;
  ccd_core_t   core_nxt;
  logic [7:0]  rx_byte;
  logic        rx_tgl;
  logic        new_byte_w;
  logic        show_w;

  // ==========================================================
  // Arithmetic helpers
  // Clamp a signed 64-bit value to 32 bits
  function automatic logic [31:0] ccd_sat(input logic [63:0] v);
    if ($signed(v) > $signed({32'h0000_0000, SAT_POS})) begin
      ccd_sat = SAT_POS;
    end else if ($signed(v) < $signed({32'hFFFF_FFFF, SAT_NEG})) begin
      ccd_sat = SAT_NEG;
    end else begin
      ccd_sat = v[31:0];
    end
  endfunction

  // Offset sits under the top 24 result bits, signed
  function automatic logic [63:0] ccd_diff(input logic [31:0] d,
                                           input logic [23:0] o);
    ccd_diff = {{32{d[31]}}, d} - {{32{o[23]}}, o, 8'h00};
  endfunction

  function automatic logic [31:0] ccd_scale(input logic [31:0] d,
                                            input logic [23:0] o,
                                            input logic [23:0] g,
                                            input logic        nogain);
    logic [63:0] df;
    logic [63:0] pr;
    df = ccd_diff(d, o);
    pr = 64'($signed(df) * $signed({40'h00_0000_0000, g}));
    if (nogain) begin
      ccd_scale = ccd_sat(df);
    end else begin
      ccd_scale = ccd_sat(64'($signed(pr) >>> GAIN_FRAC));
    end
  endfunction

  // Gain that maps the averaged reading onto full scale
  function automatic logic [23:0] ccd_gain_of(input logic [35:0] a);
    logic [35:0] avg;
    logic [53:0] q;
    avg = 36'($signed(a) >>> CAL_SHIFT);
    q   = '0;
    if ($signed(avg) <= 0) begin
      ccd_gain_of = GAIN_MAX;
    end else begin
      q = {CAL_FULL, 22'h00_0000} / {18'h0_0000, avg};
      ccd_gain_of = (|q[53:24]) ? GAIN_MAX : q[23:0];
    end
  endfunction

  function automatic logic [7:0] ccd_reg_rd(input logic [4:0]  a,
                                            input logic [23:0] o,
                                            input logic [23:0] g);
    if (a == ADDR_OFS0) ccd_reg_rd = o[7:0];
    else if (a == ADDR_OFS1) ccd_reg_rd = o[15:8];
    else if (a == ADDR_OFS2) ccd_reg_rd = o[23:16];
    else if (a == ADDR_GAIN0) ccd_reg_rd = g[7:0];
    else if (a == ADDR_GAIN1) ccd_reg_rd = g[15:8];
    else if (a == ADDR_GAIN2) ccd_reg_rd = g[23:16];
    else ccd_reg_rd = 8'h00;
  endfunction

  // ==========================================================
  // Link end on the serial clock
  ccd_link u_link (
    .sclk_in      (sclk_in),
    .nrst_in      (nrst_in),
    .din_in       (din_in),
    .dout_out     (dout_out),
    .tx_word_in   (core_r.tx_word),
    .word_mode_in (core_r.word_mode),
    .rx_byte_out  (rx_byte),
    .rx_tgl_out   (rx_tgl)
  );

  // Byte event seen after the second synchroniser stage
  assign new_byte_w = core_r.rx_s2 ^ core_r.rx_s3;
  // A result is announced only when settled and not calibrating
  assign show_w = filt_valid_in && (core_r.cont || core_r.rdc_wait) &&
                  !core_r.standby && !core_r.cal_run &&
                  (core_r.settle < 7'h02);

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [31:0] res;
    logic [35:0] acc;
    logic [63:0] dif;
    res             = '0;
    acc             = '0;
    dif             = '0;
    core_nxt        = core_r;
    core_nxt.rx_s1  = rx_tgl;
    core_nxt.rx_s2  = core_r.rx_s1;
    core_nxt.rx_s3  = core_r.rx_s2;
    core_nxt.sy_s1  = sync_in;
    core_nxt.sy_s2  = core_r.sy_s1;
    core_nxt.res_valid = 1'b0;
    core_nxt.restart   = 1'b0;
    // Ready idles high for a few clocks, then falls
    if (core_r.hi_cnt != 3'h0) begin
      core_nxt.hi_cnt = core_r.hi_cnt - 3'h1;
      if (core_r.hi_cnt == 3'h1) begin
        core_nxt.ready_n = 1'b0;
      end
    end
    // Correction path, one result per filter output
    if (filt_valid_in) begin
      if (sinc_only_in) begin
        res = filt_data_in;
      end else begin
        res = ccd_scale(filt_data_in, core_r.ofs, core_r.gain,
                        core_r.cal_run && core_r.cal_op == CAL_OFS);
      end
      core_nxt.result    = res;
      core_nxt.res_valid = 1'b1;
      if (core_r.settle != 7'h00) begin
        core_nxt.settle = core_r.settle - 7'h01;
      end
      // Averaging: offset uses raw data, gain the offset-free data
      if (core_r.cal_run) begin
        if (core_r.cal_op == CAL_OFS) begin
          acc = core_r.acc + {{4{filt_data_in[31]}}, filt_data_in};
        end else begin
          dif = ccd_diff(filt_data_in, core_r.ofs);
          acc = core_r.acc + dif[35:0];
        end
        core_nxt.acc     = acc;
        core_nxt.cal_cnt = core_r.cal_cnt - 5'h01;
        if (core_r.cal_cnt == 5'h01) begin
          core_nxt.cal_run = 1'b0;
          core_nxt.cal_op  = CAL_NONE;
          if (core_r.cal_op == CAL_OFS) begin
            core_nxt.ofs = 24'(($signed(acc) >>> CAL_SHIFT) >>> 8);
          end else begin
            core_nxt.gain = ccd_gain_of(acc);
          end
        end
      end
      if (show_w) begin
        core_nxt.tx_word  = res;
        core_nxt.ready_n  = 1'b1;
        core_nxt.hi_cnt   = READY_HIGH;
        core_nxt.rdc_wait = 1'b0;
      end
    end
    // Command decoding, one byte per link event
    if (new_byte_w) begin
      case (core_r.st)
        ST_IDLE: begin
          core_nxt.rdc_mode = 1'b0;
          if (rx_byte[7:1] == OPC_WAKE) begin
            core_nxt.standby  = 1'b0;
            core_nxt.rdc_mode = core_r.rdc_mode;  // Idle reads clock 00h
          end else if (rx_byte[7:1] == OPC_STANDBY) begin
            core_nxt.standby = 1'b1;
          end else if (rx_byte[7:1] == OPC_ALIGN) begin
            if (core_r.sy_s2) begin
              core_nxt.restart = 1'b1;
              core_nxt.settle  = SETTLE_READS;
            end
          end else if (rx_byte[7:1] == OPC_RESET) begin
            core_nxt.ofs      = OFS_RESET;
            core_nxt.gain     = GAIN_RESET;
            core_nxt.cont     = 1'b1;
            core_nxt.standby  = 1'b0;
            core_nxt.rdc_wait = 1'b0;
            core_nxt.cal_arm  = CAL_NONE;
            core_nxt.cal_op   = CAL_NONE;
            core_nxt.cal_run  = 1'b0;
            core_nxt.restart  = 1'b1;
            core_nxt.settle   = SETTLE_READS;
            core_nxt.ready_n  = 1'b1;
            core_nxt.hi_cnt   = 3'h0;
          end else if (rx_byte == CMD_CONT) begin
            core_nxt.cont = 1'b1;
            if (core_r.cal_arm != CAL_NONE) begin
              core_nxt.cal_run = 1'b1;
              core_nxt.cal_op  = core_r.cal_arm;
              core_nxt.cal_arm = CAL_NONE;
              core_nxt.cal_cnt = CAL_READS;
              core_nxt.acc     = '0;
            end
          end else if (rx_byte == CMD_STOP) begin
            core_nxt.cont    = 1'b0;
            core_nxt.ready_n = 1'b1;
            core_nxt.hi_cnt  = 3'h0;
          end else if (rx_byte == CMD_RDC) begin
            core_nxt.rdc_wait = 1'b1;
            core_nxt.rdc_mode = 1'b1;
          end else if (rx_byte[7:5] == GRP_REG_RD) begin
            core_nxt.wr   = 1'b0;
            core_nxt.addr = rx_byte[4:0];
            core_nxt.st   = ST_CNT;
          end else if (rx_byte[7:5] == GRP_REG_WR) begin
            core_nxt.wr   = 1'b1;
            core_nxt.addr = rx_byte[4:0];
            core_nxt.st   = ST_CNT;
          end else if (rx_byte == CMD_OFS_CAL) begin
            core_nxt.cal_arm = CAL_OFS;
          end else if (rx_byte == CMD_GAIN_CAL) begin
            core_nxt.cal_arm = CAL_GAIN;
          end
          // Any other byte only clears rdc_mode
        end
        ST_CNT: begin
          core_nxt.left = rx_byte[4:0];
          if (core_r.wr) begin
            core_nxt.st = ST_WR;
          end else begin
            core_nxt.st      = ST_RD;
            core_nxt.tx_word = {ccd_reg_rd(core_r.addr, core_r.ofs,
                                           core_r.gain), 24'h00_0000};
          end
        end
        ST_WR: begin
          // Host writes reach the words at any time
          if (core_r.addr == ADDR_OFS0) core_nxt.ofs[7:0] = rx_byte;
          else if (core_r.addr == ADDR_OFS1) core_nxt.ofs[15:8] = rx_byte;
          else if (core_r.addr == ADDR_OFS2) core_nxt.ofs[23:16] = rx_byte;
          else if (core_r.addr == ADDR_GAIN0) core_nxt.gain[7:0] = rx_byte;
          else if (core_r.addr == ADDR_GAIN1) core_nxt.gain[15:8] = rx_byte;
          else if (core_r.addr == ADDR_GAIN2) core_nxt.gain[23:16] = rx_byte;
          core_nxt.addr = core_r.addr + 5'h01;
          if (core_r.left == 5'h00) core_nxt.st = ST_IDLE;
          else core_nxt.left = core_r.left - 5'h01;
        end
        ST_RD: begin
          core_nxt.addr = core_r.addr + 5'h01;
          core_nxt.tx_word = {ccd_reg_rd(core_r.addr + 5'h01, core_r.ofs,
                                         core_r.gain), 24'h00_0000};
          if (core_r.left == 5'h00) core_nxt.st = ST_IDLE;
          else core_nxt.left = core_r.left - 5'h01;
        end
        default: core_nxt.st = ST_IDLE;
      endcase
    end
    // Words leave only in idle, in continuous or one-shot reads
    core_nxt.word_mode = (core_nxt.st == ST_IDLE) &&
                         (core_nxt.cont || core_nxt.rdc_mode);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_r           <= '0;
      core_r.st        <= ST_IDLE;
      core_r.ofs       <= OFS_RESET;
      core_r.gain      <= GAIN_RESET;
      core_r.cont      <= 1'b1;
      core_r.word_mode <= 1'b1;
      core_r.ready_n   <= 1'b1;
      core_r.cal_arm   <= CAL_NONE;
      core_r.cal_op    <= CAL_NONE;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign result_out         = core_r.result;
  assign result_valid_out   = core_r.res_valid;
  assign result_ready_n_out = core_r.ready_n;
  assign standby_out        = core_r.standby;
  assign restart_out        = core_r.restart;
  assign cal_busy_out       = core_r.cal_run;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_idle_byte(logic [7:0] b);
    new_byte_w && core_r.st == ST_IDLE && rx_byte == b;
  endsequence
  sequence s_ready_high;
    result_ready_n_out [*4];
  endsequence

  a_unity_pass: assert property (filt_valid_in && !sinc_only_in &&
      !core_r.cal_run && core_r.ofs == 24'h00_0000 &&
      core_r.gain == GAIN_RESET |=> result_out == $past(filt_data_in))
    else $error("unity correction altered data");
  a_sinc_bypass: assert property (filt_valid_in && sinc_only_in
      |=> result_valid_out && result_out == $past(filt_data_in))
    else $error("sinc-only data was corrected");
  a_gain_zero: assert property (filt_valid_in && !sinc_only_in &&
      !core_r.cal_run && core_r.gain == 24'h00_0000 |=> result_out == 0)
    else $error("zero gain gave nonzero result");
  a_gain_double: assert property (filt_valid_in && !sinc_only_in &&
      !core_r.cal_run && core_r.ofs == 24'h00_0000 &&
      core_r.gain == GAIN_DOUBLE && filt_data_in[31:29] == 3'h0
      |=> result_out == {$past(filt_data_in[30:0]), 1'b0})
    else $error("double gain wrong");
  a_ready_pulse: assert property (show_w |=> s_ready_high
      ##1 !result_ready_n_out)
    else $error("ready pulse shape wrong");
  a_stop_quiet: assert property (s_idle_byte(CMD_STOP)
      |=> result_ready_n_out && !core_r.word_mode && !core_r.cont)
    else $error("stop did not quiet output");
  a_cal_start: assert property (s_idle_byte(CMD_CONT) &&
      core_r.cal_arm != CAL_NONE |=> cal_busy_out &&
      core_r.cal_cnt == CAL_READS)
    else $error("calibration did not start");
  a_unknown_cmd: assert property (s_idle_byte(8'hFF) |=>
      $stable(core_r.ofs) && $stable(core_r.gain) && $stable(core_r.cont))
    else $error("unknown command changed state");
  a_reset_cmd: assert property (s_idle_byte(8'h07) |=>
      core_r.cont && core_r.gain == GAIN_RESET &&
      core_r.ofs == OFS_RESET && restart_out)
    else $error("reset command incomplete");
  a_standby_lsb: assert property (s_idle_byte(8'h03)
      |=> standby_out)
    else $error("standby opcode bit 0 not ignored");
  a_reg_two_byte: assert property (new_byte_w &&
      core_r.st == ST_IDLE && rx_byte[7:5] == GRP_REG_WR
      |=> core_r.st == ST_CNT && core_r.wr)
    else $error("register command not two bytes");
  a_settle_count: assert property (s_idle_byte(8'h04) &&
      core_r.sy_s2 |=> core_r.settle == SETTLE_READS)
    else $error("align did not start settling");
endmodule // ccd_cal_decode

// *** test/ccd_host.sv ***
// Host controller model that sends command bytes over the serial link
`timescale 1ns/100ps
module ccd_host (
  // Master clock, times the gap between bytes
  input  wire logic clk_in,
  input  wire logic dout_in,
  // Link pins toward the device
  output logic      sclk_out,
  output logic      din_out,
  output logic      sync_out
);
  // ==========================================================
  // Idle link; sync is held high so that align can act
  initial begin
    sclk_out = 1'b0;
    din_out  = 1'b0;
    sync_out = 1'b1;
  end
  // MSB first, 48 ns link clock that stands low between frames
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      din_out = b[i];
      #24 sclk_out = 1'b1;
      #24 sclk_out = 1'b0;
    end
    din_out = ~din_out; // Released line must not show a stale bit
    repeat (26) @(posedge clk_in); // Over 24 master clocks
  endtask
endmodule // ccd_host

// *** test/test_ccd_cal_decode.sv ***
// Self-checking bench for correction and command decoding
`timescale 1ns/100ps
module test_ccd_cal_decode
  import ccd_pkg::*;
;
  logic        clk_in, nrst_in, sclk_in, din_in, sync_in;
  logic        filt_valid_in, sinc_only_in, dout_out;
  logic        result_ready_n_out, result_valid_out;
  logic        standby_out, restart_out, cal_busy_out;
  logic [31:0] filt_data_in, result_out;
  logic [23:0] ofs, gain;
  logic [31:0] d;
  bit          ng;
  longint      lp;
  logic [23:0] gl[4] = '{GAIN_DOUBLE, 24'h20_0000, 24'h00_0000, GAIN_RESET};
  logic [31:0] q[$];
  int          mismatches, tests_run;
  ccd_cal_decode u_dut (.clk_in, .nrst_in, .sclk_in, .din_in, .dout_out,
    .result_ready_n_out, .sync_in, .filt_data_in, .filt_valid_in,
    .sinc_only_in, .result_out, .result_valid_out, .standby_out,
    .restart_out, .cal_busy_out);
  ccd_host u_host (.clk_in, .dout_in(dout_out), .sclk_out(sclk_in),
    .din_out(din_in), .sync_out(sync_in));
  // ==========================================================
  // 20 MHz core clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Expected result, saturated instead of wrapped
  function automatic logic [31:0] expv(input logic [31:0] d);
    longint p;
    if (sinc_only_in) return d;
    p = (longint'($signed(d)) - (longint'($signed(ofs)) <<< 8));
    if (!ng) p = (p * longint'(gain)) >>> GAIN_FRAC; // Off in offset cal
    if (p > 64'sh7FFF_FFFF) return SAT_POS;
    if (p < -64'sh8000_0000) return SAT_NEG;
    return p[31:0];
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rdy(input logic e);
    chk({31'h0, result_ready_n_out}, {31'h0, e});
  endtask
  // One filter result; its expectation is queued as it is driven
  task automatic feed(input logic [31:0] d);
    @(negedge clk_in);
    filt_data_in  = d;
    filt_valid_in = 1'b1;
    q.push_back(expv(d));
    @(negedge clk_in);
    filt_valid_in = 1'b0;
  endtask
  task automatic wr3(input logic [4:0] a, input logic [23:0] w);
    u_host.send({GRP_REG_WR, a});
    u_host.send(8'h02);
    u_host.send(w[7:0]);
    u_host.send(w[15:8]);
    u_host.send(w[23:16]);
  endtask
  task automatic test_done;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Result watcher, sampled half a cycle after the launch edge
  always @(negedge clk_in) begin
    if (result_valid_out === 1'b1)
      chk(result_out, q.size() ? q.pop_front() : ~result_out);
  end
  // Watchdog sized well beyond the roughly 100 us of traffic
  initial begin
    #500_000;
    mismatches++;
    test_done;
  end
  initial begin
    nrst_in       = 1'b0;
    filt_data_in  = 32'h0000_0000;
    filt_valid_in = 1'b0;
    sinc_only_in  = 1'b0;
    ofs           = OFS_RESET;
    gain          = GAIN_RESET;
    ng            = 1'b0;
    repeat (20) @(negedge clk_in);
    nrst_in = 1'b1;
    void'($urandom(70984));
    feed($urandom);
    repeat (6) @(negedge clk_in);
    chk_rdy(1'b0);
    u_host.send(CMD_STOP);
    feed($urandom);
    repeat (6) @(negedge clk_in);
    chk_rdy(1'b1);
    $display("test ready done");
    ofs = 24'($urandom);
    wr3(ADDR_OFS0, ofs);
    foreach (gl[i]) begin
      gain = gl[i];
      wr3(ADDR_GAIN0, gain);
      feed($urandom);
    end
    $display("test scaling done");
    ofs  = OFS_RESET;
    gain = GAIN_DOUBLE;
    wr3(ADDR_OFS0, ofs);
    wr3(ADDR_GAIN0, gain);
    feed(32'h7FFF_FFF0);
    feed(32'h8000_0010);
    sinc_only_in = 1'b1;
    feed($urandom);
    sinc_only_in = 1'b0;
    u_host.send(8'hFF);
    feed($urandom);
    u_host.send(8'h03);
    chk({31'h0, standby_out}, 32'h0000_0001);
    u_host.send(8'h00);
    chk({31'h0, standby_out}, 32'h0000_0000);
    u_host.send({OPC_RESET, 1'b1});
    ofs  = OFS_RESET;
    gain = GAIN_RESET;
    feed($urandom);
    // Align sequence: stop, align, continuous, wait for ready
    u_host.send(CMD_STOP);
    u_host.send({OPC_ALIGN, 1'b0});
    u_host.send(CMD_CONT);
    repeat (64) feed($urandom);
    repeat (6) @(negedge clk_in);
    chk_rdy(1'b0);
    u_host.send(CMD_STOP);
    gain = 24'h20_0000;
    wr3(ADDR_GAIN0, gain);
    // Offset calibration with gain bypassed while averaging
    u_host.send(CMD_OFS_CAL);
    u_host.send(CMD_CONT);
    ng = 1'b1;
    d  = {16'h0000, 16'($urandom)};
    repeat (16) feed(d);
    ng  = 1'b0;
    ofs = d[31:8];
    chk({31'h0, cal_busy_out}, 32'h0000_0000);
    feed(d);
    repeat (6) @(negedge clk_in);
    // Gain calibration: 16 readings map onto full scale
    u_host.send(CMD_STOP);
    u_host.send(CMD_GAIN_CAL);
    u_host.send(CMD_CONT);
    d = 32'h4000_0000 | ($urandom & 32'h0FFF_FFFF);
    repeat (16) feed(d);
    lp   = longint'(d) - (longint'(ofs) <<< 8);
    gain = 24'((64'sh7FFF_FFFE <<< 22) / lp);
    feed(d);
    $display("test calibration done");
    repeat (10) @(negedge clk_in);
    chk(32'(q.size()), 32'h0000_0000);
    $display("test commands done");
    test_done;
  end
endmodule // test_ccd_cal_decode
